// [design/mei_pkg.sv]
// Constants shared by the metering event interrupt unit
package mei_pkg;
  // Register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int SAMPLE_W = 16;

  // Source counts
  localparam int NUM_PHASES = 3;
  localparam int NUM_PULSES = 4;
  localparam int NUM_ZC = 4;

  // Register offsets
  localparam logic [7:0] MEASURE_FLAG_OFS = 8'h64;
  localparam logic [7:0] MEASURE_ENABLE_OFS = 8'h65;
  localparam logic [7:0] PHASE_STATUS_OFS = 8'h69;
  localparam logic [7:0] REGION_STATUS_OFS = 8'h6A;
  localparam logic [7:0] ZC_THRESHOLD_OFS = 8'h6B;
  localparam logic [7:0] SEG3_UPPER_OFS = 8'h6C;
  localparam logic [7:0] SEG3_LOWER_OFS = 8'h6D;

  // Flag and enable bit positions
  localparam int OVER_LIMIT_BIT = 15;
  localparam int VOLTAGE_DIP_BIT = 14;
  localparam int SEGMENT3_BIT = 13;
  localparam int PULSE_FIRST_BIT = 8;
  localparam int PHASE_A_ZC_BIT = 4;
  localparam logic [15:0] FLAG_IMPL_MASK = 16'hEFF0;

  // Phase status field positions, three bits each (A, B, C)
  localparam int OVERVOLT_LSB = 0;
  localparam int OVERCURR_LSB = 3;
  localparam int DIP_LSB = 6;
  localparam int PHASE_STATUS_W = 9;

  // Values after reset
  localparam logic [15:0] FLAG_RST = 16'h0000;
  localparam logic [15:0] ENABLE_RST = 16'h0000;
  localparam logic [8:0] PHASE_STATUS_RST = 9'h000;
  localparam logic [15:0] ZC_THRESHOLD_RST = 16'h0000;
  localparam logic [15:0] SEG3_UPPER_RST = 16'hFFFF;
  localparam logic [15:0] SEG3_LOWER_RST = 16'h0000;

  // Piecewise region codes of a current RMS
  localparam logic [1:0] REGION_BELOW = 2'h0;
  localparam logic [1:0] REGION_INSIDE = 2'h1;
  localparam logic [1:0] REGION_ABOVE = 2'h2;
endpackage

// [design/mei_rise_detect.sv]
// Rising edge detector for a group of synchronous levels
`timescale 1ns/1ps
module mei_rise_detect #(
  parameter int WIDTH = 4
) (
  input wire logic mclk_in, // System clock
  input wire logic sys_rst_in, // Async reset, active high
  input wire logic ce_in, // Clock enable
  input wire logic [WIDTH-1:0] level_in, // Levels to watch
  output logic [WIDTH-1:0] rise_out // High while a low-to-high step is seen
);
  logic [WIDTH-1:0] level_q;

  // Previous level, frozen with the clock enable
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      level_q <= '0;
    end else if (ce_in) begin
      level_q <= level_in;
    end
  end

  // Combinational so the flag sets in the same edge as the step
  assign rise_out = level_in & ~level_q;
endmodule // mei_rise_detect

// [design/mei_zero_cross.sv]
// Forward zero-crossing detector with magnitude threshold
`timescale 1ns/1ps
module mei_zero_cross (
  input wire logic mclk_in, // System clock
  input wire logic sys_rst_in, // Async reset, active high
  input wire logic ce_in, // Clock enable
  input wire logic sample_valid_in, // New sample strobe
  input wire logic signed [15:0] sample_in, // Current sample
  input wire logic [15:0] threshold_in, // Zero-crossing threshold
  output logic cross_out // One-cycle pulse on a qualified crossing
);
  logic neg_q;
  logic [15:0] peak_q;
  logic cross_q;
  logic [15:0] mag;

  // Magnitude of a negative sample; 16 bits hold 32768 unsigned
  assign mag = 16'(-sample_in);

  // Track the negative half-wave and its peak magnitude
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      neg_q <= 1'b0;
      peak_q <= 16'h0000;
    end else if (ce_in && sample_valid_in) begin
      if (sample_in < 0) begin
        neg_q <= 1'b1;
        peak_q <= (mag > peak_q) ? mag : peak_q;
      end else begin
        neg_q <= 1'b0;
        peak_q <= 16'h0000;
      end
    end
  end

  // Noise below the threshold never counts as a crossing
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cross_q <= 1'b0;
    end else if (ce_in) begin
      cross_q <= sample_valid_in && !(sample_in < 0) && neg_q && (peak_q > threshold_in);
    end
  end

  assign cross_out = cross_q;
endmodule // mei_zero_cross

// [design/mei_interrupt_unit.sv]
// Event flag, enable and interrupt pin logic of the measurement mode
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps

module mei_interrupt_unit (
  input wire logic mclk_in, // System clock, 100 MHz
  input wire logic sys_rst_in, // Async reset, active high
  input wire logic ce_in, // Clock enable, freezes all state
  input wire logic [7:0] reg_addr_in, // Register address
  input wire logic [15:0] reg_wdata_in, // Register write data
  input wire logic reg_wr_in, // Write strobe
  input wire logic reg_rd_in, // Read strobe
  output logic [15:0] reg_rdata_out, // Read data, cycle after strobe
  input wire logic [2:0] overvolt_in, // Per-phase overvoltage judgement
  input wire logic [2:0] overcurr_in, // Per-phase overcurrent judgement
  input wire logic [2:0] dip_in, // Per-phase voltage sag judgement
  input wire logic [15:0] irms_a_in, // Phase A current RMS, high bits
  input wire logic [15:0] irms_b_in, // Phase B current RMS, high bits
  input wire logic [15:0] irms_c_in, // Phase C current RMS, high bits
  input wire logic pulse_out_first_in, // First energy pulse output
  input wire logic pulse_out_second_in, // Second energy pulse output
  input wire logic pulse_out_third_in, // Third energy pulse output
  input wire logic pulse_out_fourth_in, // Fourth energy pulse output
  input wire logic sample_valid_in, // Current sample strobe
  input wire logic signed [15:0] sample_a_in, // Phase A current sample
  input wire logic signed [15:0] sample_b_in, // Phase B current sample
  input wire logic signed [15:0] sample_c_in, // Phase C current sample
  input wire logic signed [15:0] sample_n_in, // Neutral current sample
  output logic irq_out_n // Interrupt pin, active low
);
  // Register storage
  logic over_limit_flag_q;
  logic voltage_dip_flag_q;
  logic segment3_change_flag_q;
  logic [3:0] pulse_flag_q;
  logic [3:0] zc_flag_q;
  logic [15:0] enable_q;
  logic [8:0] phase_status_q;
  logic [15:0] zero_cross_threshold_q;
  logic [15:0] segment3_upper_bound_q;
  logic [15:0] segment3_lower_bound_q;
  logic [1:0] region_q [3];
  logic region_live_q;
  logic [15:0] rdata_q;

  // Combinational helpers
  logic [15:0] flag_word;
  logic [15:0] flag_clr;
  logic flag_wr;
  logic [3:0] pulse_level;
  logic [3:0] pulse_rise;
  logic [3:0] zc_cross;
  logic [15:0] irms [3];
  logic signed [15:0] zc_sample [4];
  logic [1:0] region_d [3];
  logic [2:0] region_moved;
  logic [15:0] read_value;
  logic over_event;
  logic dip_event;

  // Address match, shared by write and read decode
  // One function so write and read decode cannot drift apart
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  // Region of one RMS value against the segment-3 bounds
  function automatic logic [1:0] region_of(input logic [15:0] rms, input logic [15:0] upper,
                                           input logic [15:0] lower);
    if (rms > upper) begin
      region_of = mei_pkg::REGION_ABOVE;
    end else if (rms < lower) begin
      region_of = mei_pkg::REGION_BELOW;
    end else begin
      region_of = mei_pkg::REGION_INSIDE;
    end
  endfunction

  // Source groups packed for the loops below
  assign pulse_level = {pulse_out_fourth_in, pulse_out_third_in, pulse_out_second_in, pulse_out_first_in};
  assign irms[0] = irms_a_in;
  assign irms[1] = irms_b_in;
  assign irms[2] = irms_c_in;
  assign zc_sample[0] = sample_a_in;
  assign zc_sample[1] = sample_b_in;
  assign zc_sample[2] = sample_c_in;
  assign zc_sample[3] = sample_n_in;

  // Any phase judged out of limits or sagging this cycle
  assign over_event = |overvolt_in || |overcurr_in;
  assign dip_event = |dip_in;

  // Write-one-to-clear strobes on the flag register
  assign flag_wr = ce_in && reg_wr_in && reg_hit(reg_addr_in, mei_pkg::MEASURE_FLAG_OFS);
  assign flag_clr = flag_wr ? reg_wdata_in : 16'h0000;

  // Pulse outputs are watched for their low-to-high step
  mei_rise_detect #(
    .WIDTH(mei_pkg::NUM_PULSES)
  ) u_pulse_rise (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .level_in(pulse_level),
    .rise_out(pulse_rise)
  );

  // One crossing detector per current channel: A, B, C, neutral
  generate
    for (genvar g = 0; g < mei_pkg::NUM_ZC; g++) begin : g_zc
      mei_zero_cross u_zc (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .ce_in(ce_in),
        .sample_valid_in(sample_valid_in),
        .sample_in(zc_sample[g]),
        .threshold_in(zero_cross_threshold_q),
        .cross_out(zc_cross[g])
      );
    end
  endgenerate

  // Current piecewise region of each phase
  generate
    for (genvar p = 0; p < mei_pkg::NUM_PHASES; p++) begin : g_region
      assign region_d[p] = region_of(irms[p], segment3_upper_bound_q, segment3_lower_bound_q);
      assign region_moved[p] = region_live_q && (region_d[p] != region_q[p]);
    end
  endgenerate

  // Remembered regions; the first valid cycle only primes them
  // Bound writes can move a region too, which counts as a change
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      region_live_q <= 1'b0;
      for (int p = 0; p < mei_pkg::NUM_PHASES; p++) begin
        region_q[p] <= mei_pkg::REGION_BELOW;
      end
    end else if (ce_in) begin
      region_live_q <= 1'b1;
      for (int p = 0; p < mei_pkg::NUM_PHASES; p++) begin
        region_q[p] <= region_d[p];
      end
    end
  end

  // Over-limit flag; a new event beats a clear in the same cycle
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      over_limit_flag_q <= 1'b0;
    end else if (ce_in) begin
      if (over_event) begin
        over_limit_flag_q <= 1'b1;
      end else if (flag_clr[mei_pkg::OVER_LIMIT_BIT]) begin
        over_limit_flag_q <= 1'b0;
      end
    end
  end

  // Voltage-dip flag
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      voltage_dip_flag_q <= 1'b0;
    end else if (ce_in) begin
      if (dip_event) begin
        voltage_dip_flag_q <= 1'b1;
      end else if (flag_clr[mei_pkg::VOLTAGE_DIP_BIT]) begin
        voltage_dip_flag_q <= 1'b0;
      end
    end
  end

  // Segment-3 region change flag
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      segment3_change_flag_q <= 1'b0;
    end else if (ce_in) begin
      if (|region_moved) begin
        segment3_change_flag_q <= 1'b1;
      end else if (flag_clr[mei_pkg::SEGMENT3_BIT]) begin
        segment3_change_flag_q <= 1'b0;
      end
    end
  end

  // Energy pulse flags, first to fourth at bits 8 to 11
  // A level held high through a clear does not set again
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pulse_flag_q <= 4'h0;
    end else if (ce_in) begin
      for (int i = 0; i < mei_pkg::NUM_PULSES; i++) begin
        if (pulse_rise[i]) begin
          pulse_flag_q[i] <= 1'b1;
        end else if (flag_clr[mei_pkg::PULSE_FIRST_BIT + i]) begin
          pulse_flag_q[i] <= 1'b0;
        end
      end
    end
  end

  // Zero-crossing flags, A, B, C, neutral at bits 4 to 7
  // Crossing pulse lags the sample strobe by one edge
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      zc_flag_q <= 4'h0;
    end else if (ce_in) begin
      for (int i = 0; i < mei_pkg::NUM_ZC; i++) begin
        if (zc_cross[i]) begin
          zc_flag_q[i] <= 1'b1;
        end else if (flag_clr[mei_pkg::PHASE_A_ZC_BIT + i]) begin
          zc_flag_q[i] <= 1'b0;
        end
      end
    end
  end

  // Phase status bits follow the clear of their summary flag
  // Same set-wins order as the summary flags
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      phase_status_q <= mei_pkg::PHASE_STATUS_RST;
    end else if (ce_in) begin
      for (int p = 0; p < mei_pkg::NUM_PHASES; p++) begin
        if (overvolt_in[p]) begin
          phase_status_q[mei_pkg::OVERVOLT_LSB + p] <= 1'b1;
        end else if (flag_clr[mei_pkg::OVER_LIMIT_BIT]) begin
          phase_status_q[mei_pkg::OVERVOLT_LSB + p] <= 1'b0;
        end
        if (overcurr_in[p]) begin
          phase_status_q[mei_pkg::OVERCURR_LSB + p] <= 1'b1;
        end else if (flag_clr[mei_pkg::OVER_LIMIT_BIT]) begin
          phase_status_q[mei_pkg::OVERCURR_LSB + p] <= 1'b0;
        end
        if (dip_in[p]) begin
          phase_status_q[mei_pkg::DIP_LSB + p] <= 1'b1;
        end else if (flag_clr[mei_pkg::VOLTAGE_DIP_BIT]) begin
          phase_status_q[mei_pkg::DIP_LSB + p] <= 1'b0;
        end
      end
    end
  end

  // Enable register; unimplemented bits stay zero
  // Pin follows it combinationally, so a write acts at once
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      enable_q <= mei_pkg::ENABLE_RST;
    end else if (ce_in && reg_wr_in && reg_hit(reg_addr_in, mei_pkg::MEASURE_ENABLE_OFS)) begin
      enable_q <= reg_wdata_in & mei_pkg::FLAG_IMPL_MASK;
    end
  end

  // Detector settings
  // A new threshold applies from the next sample on
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      zero_cross_threshold_q <= mei_pkg::ZC_THRESHOLD_RST;
      segment3_upper_bound_q <= mei_pkg::SEG3_UPPER_RST;
      segment3_lower_bound_q <= mei_pkg::SEG3_LOWER_RST;
    end else if (ce_in && reg_wr_in) begin
      if (reg_hit(reg_addr_in, mei_pkg::ZC_THRESHOLD_OFS)) begin
        zero_cross_threshold_q <= reg_wdata_in;
      end
      if (reg_hit(reg_addr_in, mei_pkg::SEG3_UPPER_OFS)) begin
        segment3_upper_bound_q <= reg_wdata_in;
      end
      if (reg_hit(reg_addr_in, mei_pkg::SEG3_LOWER_OFS)) begin
        segment3_lower_bound_q <= reg_wdata_in;
      end
    end
  end

  // Flag word as software sees it; bits 12 and 3..0 read zero
  always_comb begin
    flag_word = mei_pkg::FLAG_RST;
    flag_word[mei_pkg::OVER_LIMIT_BIT] = over_limit_flag_q;
    flag_word[mei_pkg::VOLTAGE_DIP_BIT] = voltage_dip_flag_q;
    flag_word[mei_pkg::SEGMENT3_BIT] = segment3_change_flag_q;
    for (int i = 0; i < mei_pkg::NUM_PULSES; i++) begin
      flag_word[mei_pkg::PULSE_FIRST_BIT + i] = pulse_flag_q[i];
    end
    for (int i = 0; i < mei_pkg::NUM_ZC; i++) begin
      flag_word[mei_pkg::PHASE_A_ZC_BIT + i] = zc_flag_q[i];
    end
  end

  // Read multiplexer; unmapped addresses answer zero
  // Status words are read-only; writes to them fall through
  always_comb begin
    read_value = 16'h0000;
    if (reg_hit(reg_addr_in, mei_pkg::MEASURE_FLAG_OFS)) begin
      read_value = flag_word;
    end else if (reg_hit(reg_addr_in, mei_pkg::MEASURE_ENABLE_OFS)) begin
      read_value = enable_q;
    end else if (reg_hit(reg_addr_in, mei_pkg::PHASE_STATUS_OFS)) begin
      read_value = {7'h00, phase_status_q};
    end else if (reg_hit(reg_addr_in, mei_pkg::REGION_STATUS_OFS)) begin
      read_value = {10'h000, region_q[2], region_q[1], region_q[0]};
    end else if (reg_hit(reg_addr_in, mei_pkg::ZC_THRESHOLD_OFS)) begin
      read_value = zero_cross_threshold_q;
    end else if (reg_hit(reg_addr_in, mei_pkg::SEG3_UPPER_OFS)) begin
      read_value = segment3_upper_bound_q;
    end else if (reg_hit(reg_addr_in, mei_pkg::SEG3_LOWER_OFS)) begin
      read_value = segment3_lower_bound_q;
    end
  end

  // Read data stand only in the cycle after the strobe
  // Zero outside reads keeps the port quiet on a shared bus
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_q <= 16'h0000;
    end else if (ce_in) begin
      rdata_q <= reg_rd_in ? read_value : 16'h0000;
    end
  end

  // Registered read data straight to the port
  assign reg_rdata_out = rdata_q;

  // Pin is a level: low as long as any enabled flag holds
  // No flop on the pin: it falls in the edge the flag sets
  assign irq_out_n = ~|(flag_word & enable_q);
endmodule // mei_interrupt_unit

// [testbench/mei_interrupt_unit_asserts.sv]
// Port-level checker for the metering event interrupt unit
`timescale 1ns/1ps
module mei_interrupt_unit_chk (
  input wire logic mclk_in, // System clock
  input wire logic sys_rst_in, // Async reset
  input wire logic ce_in, // Clock enable
  input wire logic [7:0] reg_addr_in, // Register address
  input wire logic [15:0] reg_wdata_in, // Write data
  input wire logic reg_wr_in, // Write strobe
  input wire logic reg_rd_in, // Read strobe
  input wire logic [15:0] reg_rdata_out, // Read data
  input wire logic [2:0] overvolt_in, // Overvoltage levels
  input wire logic [2:0] overcurr_in, // Overcurrent levels
  input wire logic [2:0] dip_in, // Sag levels
  input wire logic pulse_out_first_in, // Pulse one
  input wire logic pulse_out_second_in, // Pulse two
  input wire logic pulse_out_third_in, // Pulse three
  input wire logic pulse_out_fourth_in, // Pulse four
  input wire logic irq_out_n // Interrupt pin
);
  logic [15:0] en_q;
  logic en_wr;
  logic [3:0] pv;

  // Shadow of the enable word; unimplemented bits never stick
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      en_q <= 16'h0000;
    end else if (ce_in && en_wr) begin
      en_q <= reg_wdata_in & mei_pkg::FLAG_IMPL_MASK;
    end
  end

  // Decoded helpers
  assign en_wr = reg_wr_in && (reg_addr_in == mei_pkg::MEASURE_ENABLE_OFS);
  assign pv = {pulse_out_fourth_in, pulse_out_third_in, pulse_out_second_in, pulse_out_first_in};

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_read(logic [7:0] a);
    ce_in && reg_rd_in && reg_addr_in == a;
  endsequence

  property p_rdata_idle;
    (ce_in && !reg_rd_in) |=> reg_rdata_out == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside a read");
  property p_unmapped;
    (ce_in && reg_rd_in && !(reg_addr_in inside {[8'h64:8'h65], [8'h69:8'h6D]})) |=> reg_rdata_out == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_enable_rd;
    s_read(mei_pkg::MEASURE_ENABLE_OFS) |=> reg_rdata_out == $past(en_q);
  endproperty
  a_enable_rd: assert property (p_enable_rd) else $error("enable readback wrong");
  property p_flag_mask;
    s_read(mei_pkg::MEASURE_FLAG_OFS) |=> (reg_rdata_out & ~mei_pkg::FLAG_IMPL_MASK) == 16'h0000;
  endproperty
  a_flag_mask: assert property (p_flag_mask) else $error("unused flag bit set");
  property p_over_irq;
    (ce_in && |(overvolt_in | overcurr_in) && en_q[15] && !en_wr) |=> !irq_out_n;
  endproperty
  a_over_irq: assert property (p_over_irq) else $error("over-limit did not pull pin");
  property p_dip_irq;
    (ce_in && |dip_in && en_q[14] && !en_wr) |=> !irq_out_n;
  endproperty
  a_dip_irq: assert property (p_dip_irq) else $error("sag did not pull pin");
  property p_pulse_irq;
    (ce_in && $past(ce_in) && |(pv & ~$past(pv) & en_q[11:8]) && !en_wr) |=> !irq_out_n;
  endproperty
  a_pulse_irq: assert property (p_pulse_irq) else $error("pulse edge did not pull pin");
  property p_irq_hold;
    (!irq_out_n && !reg_wr_in) |=> !irq_out_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("pin released without a write");
  property p_no_enable;
    (en_q == 16'h0000) |-> irq_out_n;
  endproperty
  a_no_enable: assert property (p_no_enable) else $error("pin low with nothing enabled");
endmodule // mei_interrupt_unit_chk

bind mei_interrupt_unit mei_interrupt_unit_chk i_chk (
  .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .overvolt_in(overvolt_in), .overcurr_in(overcurr_in), .dip_in(dip_in),
  .pulse_out_first_in(pulse_out_first_in), .pulse_out_second_in(pulse_out_second_in),
  .pulse_out_third_in(pulse_out_third_in), .pulse_out_fourth_in(pulse_out_fourth_in), .irq_out_n(irq_out_n)
);

// [testbench/mei_host_model.sv]
// Host-side model that watches the interrupt pin
`timescale 1ns/1ps
module mei_host_model (
  input wire logic mclk_in, // System clock
  input wire logic irq_out_n, // Interrupt pin from the unit
  output int falls_out // High-to-low steps seen
);
  logic seen_q = 1'b1;
  int cnt = 0;

  // Level pin: service once per drop, not once per cycle low
  always @(posedge mclk_in) begin
    seen_q <= irq_out_n;
    if (seen_q === 1'b1 && irq_out_n === 1'b0) begin
      cnt <= cnt + 1;
    end
  end
  assign falls_out = cnt;
endmodule // mei_host_model

// [testbench/test_mei_interrupt_unit.sv]
// Self-checking bench for the metering event interrupt unit
`timescale 1ns/1ps
module test_mei_interrupt_unit;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [2:0] ov = 3'h0;
  logic [2:0] oc = 3'h0;
  logic [2:0] dip = 3'h0;
  logic [15:0] irms_b = 16'h01F4;
  logic [3:0] pls = 4'h0;
  logic valid = 1'b0;
  logic signed [15:0] smp [4] = '{4{16'sh0000}};
  logic irq_n;
  int falls;
  int fails = 0;
  int checks = 0;

  always #5 mclk_in = ~mclk_in;

  mei_interrupt_unit i_dut (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ce_in(ce), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .overvolt_in(ov), .overcurr_in(oc), .dip_in(dip),
    .irms_a_in(16'h01F4), .irms_b_in(irms_b), .irms_c_in(16'h01F4), .pulse_out_first_in(pls[0]),
    .pulse_out_second_in(pls[1]), .pulse_out_third_in(pls[2]), .pulse_out_fourth_in(pls[3]),
    .sample_valid_in(valid), .sample_a_in(smp[0]), .sample_b_in(smp[1]), .sample_c_in(smp[2]),
    .sample_n_in(smp[3]), .irq_out_n(irq_n)
  );
  mei_host_model i_host (.mclk_in(mclk_in), .irq_out_n(irq_n), .falls_out(falls));

  // Shared compare and bus tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge mclk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask
  task automatic irq_chk(input logic exp);
    #1;
    check({15'h0000, irq_n}, {15'h0000, exp});
  endtask

  // Reset values, enable mask, read-only and unmapped places
  task automatic t_regs();
    rd_chk(8'h64, 16'h0000);
    irq_chk(1'b1);
    wr_reg(8'h65, 16'hFFFF);
    rd_chk(8'h65, 16'hEFF0);
    wr_reg(8'h69, 16'h01FF);
    rd_chk(8'h69, 16'h0000);
    rd_chk(8'h70, 16'h0000);
  endtask
  // Over-limit and sag: set, phase bits, write-1 clear
  task automatic t_levels();
    @(posedge mclk_in);
    ov <= 3'h2;
    oc <= 3'h4;
    @(posedge mclk_in);
    ov <= 3'h0;
    oc <= 3'h0;
    irq_chk(1'b0);
    rd_chk(8'h64, 16'h8000);
    rd_chk(8'h69, 16'h0022);
    check(16'(falls), 16'h0001);
    wr_reg(8'h64, 16'h8000);
    irq_chk(1'b1);
    rd_chk(8'h69, 16'h0000);
    @(posedge mclk_in);
    dip <= 3'h1;
    @(posedge mclk_in);
    dip <= 3'h0;
    rd_chk(8'h64, 16'h4000);
    rd_chk(8'h69, 16'h0040);
    wr_reg(8'h64, 16'h4000);
    rd_chk(8'h64, 16'h0000);
    rd_chk(8'h69, 16'h0000);
  endtask
  // Pulse edges; level held through the clear must not set again
  task automatic t_pulse();
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_in);
      pls[i] <= 1'b1;
      rd_chk(8'h64, 16'h0100 << i);
      wr_reg(8'h64, 16'h0100 << i);
      rd_chk(8'h64, 16'h0000);
      irq_chk(1'b1);
      @(posedge mclk_in);
      pls[i] <= 1'b0;
    end
    wr_reg(8'h65, 16'hE0F0);
    @(posedge mclk_in);
    pls[3] <= 1'b1;
    rd_chk(8'h64, 16'h0800);
    irq_chk(1'b1);
    wr_reg(8'h64, 16'h0800);
    wr_reg(8'h65, 16'hEFF0);
  endtask
  // One negative half-wave then a forward step on channel ch
  task automatic zc_wave(input int ch, input logic signed [15:0] neg);
    @(posedge mclk_in);
    smp[ch] <= neg;
    valid <= 1'b1;
    @(posedge mclk_in);
    smp[ch] <= 16'sh0032;
    @(posedge mclk_in);
    valid <= 1'b0;
    repeat (2) @(posedge mclk_in);
  endtask
  // Threshold is strict: peak equal to it must not flag
  task automatic t_zc();
    wr_reg(8'h6B, 16'h0064);
    rd_chk(8'h6B, 16'h0064);
    for (int ch = 0; ch < 4; ch++) begin
      zc_wave(ch, -16'sd100);
      rd_chk(8'h64, 16'h0000);
      zc_wave(ch, -16'sd101);
      rd_chk(8'h64, 16'h0010 << ch);
      wr_reg(8'h64, 16'h0010 << ch);
      rd_chk(8'h64, 16'h0000);
    end
  endtask
  // Phase B leaves the inside band for above
  task automatic t_seg();
    wr_reg(8'h6C, 16'h03E8);
    wr_reg(8'h6D, 16'h0064);
    rd_chk(8'h6C, 16'h03E8);
    rd_chk(8'h6D, 16'h0064);
    rd_chk(8'h64, 16'h0000);
    @(posedge mclk_in);
    irms_b <= 16'h07D0;
    rd_chk(8'h64, 16'h2000);
    rd_chk(8'h6A, 16'h0019);
    wr_reg(8'h64, 16'h2000);
    rd_chk(8'h64, 16'h0000);
    irq_chk(1'b1);
  endtask

  // Clock enable low: an event seen only then leaves no trace
  task automatic t_freeze();
    @(posedge mclk_in);
    ce <= 1'b0;
    ov <= 3'h1;
    @(posedge mclk_in);
    ov <= 3'h0;
    @(posedge mclk_in);
    ce <= 1'b1;
    rd_chk(8'h64, 16'h0000);
    rd_chk(8'h69, 16'h0000);
    irq_chk(1'b1);
  endtask

  task automatic give_verdict();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    t_regs();
    t_levels();
    t_pulse();
    t_zc();
    t_seg();
    t_freeze();
    give_verdict();
  end
  // Watchdog, well beyond the roughly 180 cycles the tests need
  initial begin
    repeat (5000) @(posedge mclk_in);
    fails++;
    give_verdict();
  end
endmodule // test_mei_interrupt_unit
